// ---- rtl/adc_readback_path.sv ----
/*
 ADC sample filter and the three-read readback sequence.
 Assumes samples and strobes are on the same clock as the caller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "radio_aux_defines.svh"

module adc_readback_path
   import radio_aux_pkg::*;
(
   input  wire logic           ref_clk,
   input  wire logic           nrst,
   input  wire logic           clear,
   input  wire adc_filter_type filt_mode,
   input  wire logic [7:0]     adc_sample,
   input  wire logic           agc_tick,
   input  wire logic           modem_cfg_read,
   input  wire logic           rd_hi,
   input  wire logic           rd_lo,
   output logic [7:0]          captured,
   output logic                second_hi,
   output logic [7:0]          agc_sample
);
   import radio_aux_pkg::*;

   logic [7:0] filt_r, filt_nxt;
   logic [7:0] cap_r, cap_nxt;
   logic       seq_r, seq_nxt;
   logic [7:0] agc_r, agc_nxt;
   logic [8:0] sum;
   logic       filt_upd;

   // ==========================================================
   // filter and sequence next state
   always_comb begin
      sum      = {1'b0, filt_r} + {1'b0, adc_sample};
      filt_upd = 1'b0;
      case (filt_mode)
         filt_rb_on_read: filt_upd = modem_cfg_read;
         filt_rb_on_tick: filt_upd = agc_tick;
         filt_all:        filt_upd = agc_tick;
         default:         filt_upd = 1'b0;
      endcase
      filt_nxt = filt_upd ? sum[8:1] : filt_r;  // two-tap average, cheap
      cap_nxt  = cap_r;
      seq_nxt  = seq_r;
      // first high read latches a sample, low read arms the second high read
      if (rd_hi && !seq_r) begin
         cap_nxt = (filt_mode == filt_none) ? adc_sample : filt_r;
      end else if (rd_hi && seq_r) begin
         seq_nxt = 1'b0;
      end else if (rd_lo) begin
         seq_nxt = 1'b1;
      end
      // gain loop sees the filter only in the full mode
      agc_nxt = (filt_mode == filt_all) ? filt_r : adc_sample;
      if (clear) begin
         filt_nxt = `RST_BYTE;
         cap_nxt  = `RST_BYTE;
         seq_nxt  = 1'b0;
      end
   end

   // registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         filt_r <= `RST_BYTE;
         cap_r  <= `RST_BYTE;
         seq_r  <= 1'b0;
         agc_r  <= `RST_BYTE;
      end else begin
         filt_r <= filt_nxt;
         cap_r  <= cap_nxt;
         seq_r  <= seq_nxt;
         agc_r  <= agc_nxt;
      end
   end

   assign captured   = cap_r;
   assign second_hi  = seq_r;
   assign agc_sample = agc_r;

endmodule

`default_nettype wire

// ---- rtl/radio_aux_control_registers.sv ----
/*
 Auxiliary radio control registers: external amplifier controls, wake-up
 timer settings and ADC configuration with readback. Assumes an SPI command
 decoder on ref_clk presents one memory access per cycle, and that radio
 state, ADC sample and timer status come from logic on the same clock.
*/
`include "radio_aux_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - with the amplifier output enable set, the PA control is high only in transmit.
// - with the receive amplifier enable set, the LNA control is high only in receive.
// - the pin select bit routes both controls to the 1.8 V pair or the supply-level pair.
// - entering sleep returns all modem configuration registers to their defaults.
// - a wake-up value high byte waits and reaches the timer only with the low byte.
// - filter code 00 filters nothing and code 11 filters gain loop and readback.
// - codes 01 and 10 filter only the readback, refreshed per read or per gain tick.
// - clearing the reference power bit powers the ADC reference down.
// - high read starts a readback, low read gives bits 1:0, next high read bits 7:2.
module radio_aux_control_registers
   import radio_aux_pkg::*;
(
   input  wire logic                          ref_clk,
   input  wire logic                          nrst,
   input  wire radio_aux_pkg::mem_req_type    mem_req,
   output logic [7:0]                         mem_rdata,
   output logic                               mem_rvalid,
   input  wire radio_aux_pkg::radio_state_type radio_state,
   output radio_aux_pkg::amp_pins_type        amp_pins,
   output radio_aux_pkg::wakeup_ctrl_type     wakeup_ctrl,
   input  wire logic [7:0]                    wakeup_status,
   input  wire logic [7:0]                    adc_sample,
   output logic [7:0]                         adc_source_sel,
   output logic                               adc_ref_power_on,
   output logic                               agc_filter_on,
   output logic [7:0]                         agc_sample
);
   import radio_aux_pkg::*;

   // ==========================================================
   // register state
   logic [7:0]      opt_r,      opt_nxt;
   logic [7:0]      pinsel_r,   pinsel_nxt;
   logic [7:0]      wcfg_hi_r,  wcfg_hi_nxt;
   logic [7:0]      wcfg_lo_r,  wcfg_lo_nxt;
   logic [7:0]      wval_hi_r,  wval_hi_nxt;
   logic [7:0]      wval_lo_r,  wval_lo_nxt;
   logic [7:0]      acfg_lo_r,  acfg_lo_nxt;
   logic [7:0]      acfg_hi_r,  acfg_hi_nxt;
   wakeup_ctrl_type wctl_r,     wctl_nxt;
   amp_pins_type    pins_r,     pins_nxt;
   logic [7:0]      rdata_r,    rdata_nxt;
   logic            rvalid_r,   rvalid_nxt;
   logic [7:0]      div_r,      div_nxt;
   logic            tick_r,     tick_nxt;

   logic            in_sleep;
   logic            wr_hit_cfg;
   logic            rd_rb_hi;
   logic            rd_rb_lo;
   logic            modem_cfg_rd;
   logic [7:0]      rb_captured;
   logic            rb_second_hi;
   adc_filter_type  filt_mode;
   logic            pa_level;
   logic            lna_level;

   // address match used by both write and read decoding
   function automatic logic hit(input logic [9:0] addr, input logic [9:0] off);
      hit = (addr == off);
   endfunction

   // true for addresses inside the volatile modem configuration page
   function automatic logic modem_page(input logic [9:0] addr);
      modem_page = (addr[9:8] == `MODEM_CFG_PAGE);
   endfunction

   assign in_sleep     = (radio_state == sleep_state);
   assign wr_hit_cfg   = mem_req.wr && !in_sleep;
   assign rd_rb_hi     = mem_req.rd && hit(mem_req.addr, `OFF_ADC_READBACK_HI);
   assign rd_rb_lo     = mem_req.rd && hit(mem_req.addr, `OFF_ADC_READBACK_LO);
   assign modem_cfg_rd = mem_req.rd && modem_page(mem_req.addr);
   assign filt_mode    = adc_filter_type'(acfg_hi_r[`FLD_ADC_FILT_HI:`FLD_ADC_FILT_LO]);

   // ==========================================================
   // gain-control clock enable from a free divider
   always_comb begin
      tick_nxt = 1'b0;
      div_nxt  = div_r + 8'd1;
      if (div_r == (`AGC_TICK_DIV - 8'd1)) begin
         div_nxt  = 8'd0;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         div_r  <= 8'd0;
         tick_r <= 1'b0;
      end else begin
         div_r  <= div_nxt;
         tick_r <= tick_nxt;
      end
   end

   // ==========================================================
   // register writes; the modem page is wiped while asleep
   always_comb begin
      opt_nxt     = opt_r;
      pinsel_nxt  = pinsel_r;
      wcfg_hi_nxt = wcfg_hi_r;
      wcfg_lo_nxt = wcfg_lo_r;
      wval_hi_nxt = wval_hi_r;
      wval_lo_nxt = wval_lo_r;
      acfg_lo_nxt = acfg_lo_r;
      acfg_hi_nxt = acfg_hi_r;
      wctl_nxt    = wctl_r;
      wctl_nxt.value_load = 1'b0;
      wctl_nxt.flag_clear = 1'b0;
      // option registers live outside the modem page and survive sleep
      if (mem_req.wr) begin
         if (hit(mem_req.addr, `OFF_OPERATING_OPTION)) begin
            opt_nxt = mem_req.wdata;
         end else if (hit(mem_req.addr, `OFF_EXT_AMP_PIN_SEL)) begin
            pinsel_nxt = mem_req.wdata;
         end
      end
      if (wr_hit_cfg) begin
         if (hit(mem_req.addr, `OFF_WAKEUP_CFG_HI)) begin
            wcfg_hi_nxt = mem_req.wdata;
         end else if (hit(mem_req.addr, `OFF_WAKEUP_CFG_LO)) begin
            // host keeps the high byte current before this write
            wcfg_lo_nxt = mem_req.wdata;
            wctl_nxt.config_word = {wcfg_hi_r, mem_req.wdata};
         end else if (hit(mem_req.addr, `OFF_WAKEUP_VAL_HI)) begin
            wval_hi_nxt = mem_req.wdata;
         end else if (hit(mem_req.addr, `OFF_WAKEUP_VAL_LO)) begin
            // pending high byte goes out together with the low byte
            wval_lo_nxt = mem_req.wdata;
            wctl_nxt.value_word = {wval_hi_r, mem_req.wdata};
            wctl_nxt.value_load = 1'b1;
         end else if (hit(mem_req.addr, `OFF_WAKEUP_FLAG_CLEAR)) begin
            wctl_nxt.flag_clear = 1'b1;
         end else if (hit(mem_req.addr, `OFF_ADC_CONFIG_LO)) begin
            acfg_lo_nxt = mem_req.wdata;
         end else if (hit(mem_req.addr, `OFF_ADC_CONFIG_HI)) begin
            // reserved low nibble is stored as written; host writes ones
            acfg_hi_nxt = mem_req.wdata;
         end
      end
      if (in_sleep) begin
         wcfg_hi_nxt = `RST_WAKEUP_CFG;
         wcfg_lo_nxt = `RST_WAKEUP_CFG;
         wval_hi_nxt = `RST_WAKEUP_VAL;
         wval_lo_nxt = `RST_WAKEUP_VAL;
         acfg_lo_nxt = `RST_ADC_CONFIG_LO;
         acfg_hi_nxt = `RST_ADC_CONFIG_HI;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         opt_r     <= `RST_OPERATING_OPTION;
         pinsel_r  <= `RST_EXT_AMP_PIN_SEL;
         wcfg_hi_r <= `RST_WAKEUP_CFG;
         wcfg_lo_r <= `RST_WAKEUP_CFG;
         wval_hi_r <= `RST_WAKEUP_VAL;
         wval_lo_r <= `RST_WAKEUP_VAL;
         acfg_lo_r <= `RST_ADC_CONFIG_LO;
         acfg_hi_r <= `RST_ADC_CONFIG_HI;
         wctl_r    <= '0;
      end else begin
         opt_r     <= opt_nxt;
         pinsel_r  <= pinsel_nxt;
         wcfg_hi_r <= wcfg_hi_nxt;
         wcfg_lo_r <= wcfg_lo_nxt;
         wval_hi_r <= wval_hi_nxt;
         wval_lo_r <= wval_lo_nxt;
         acfg_lo_r <= acfg_lo_nxt;
         acfg_hi_r <= acfg_hi_nxt;
         wctl_r    <= wctl_nxt;
      end
   end

   // ==========================================================
   // ADC readback path, cleared with the rest of the modem page
   adc_readback_path u_readback (
      .ref_clk        (ref_clk),
      .nrst           (nrst),
      .clear          (in_sleep),
      .filt_mode      (filt_mode),
      .adc_sample     (adc_sample),
      .agc_tick       (tick_r),
      .modem_cfg_read (modem_cfg_rd),
      .rd_hi          (rd_rb_hi),
      .rd_lo          (rd_rb_lo),
      .captured       (rb_captured),
      .second_hi      (rb_second_hi),
      .agc_sample     (agc_sample)
   );

   // ==========================================================
   // read data, one cycle after the request
   always_comb begin
      rdata_nxt  = rdata_r;
      rvalid_nxt = mem_req.rd;
      if (mem_req.rd) begin
         if (hit(mem_req.addr, `OFF_OPERATING_OPTION)) begin
            rdata_nxt = opt_r;
         end else if (hit(mem_req.addr, `OFF_EXT_AMP_PIN_SEL)) begin
            rdata_nxt = pinsel_r;
         end else if (hit(mem_req.addr, `OFF_WAKEUP_CFG_HI)) begin
            rdata_nxt = wcfg_hi_r;
         end else if (hit(mem_req.addr, `OFF_WAKEUP_CFG_LO)) begin
            rdata_nxt = wcfg_lo_r;
         end else if (hit(mem_req.addr, `OFF_WAKEUP_VAL_HI)) begin
            rdata_nxt = wval_hi_r;
         end else if (hit(mem_req.addr, `OFF_WAKEUP_VAL_LO)) begin
            rdata_nxt = wval_lo_r;
         end else if (hit(mem_req.addr, `OFF_WAKEUP_STATE)) begin
            rdata_nxt = wakeup_status;
         end else if (rd_rb_hi) begin
            // the opening read only starts the sequence and returns zero
            rdata_nxt = rb_second_hi ? {2'b00, rb_captured[7:2]} : `RST_BYTE;
         end else if (rd_rb_lo) begin
            rdata_nxt = {6'b000000, rb_captured[1:0]};
         end else if (hit(mem_req.addr, `OFF_ADC_CONFIG_LO)) begin
            rdata_nxt = acfg_lo_r;
         end else if (hit(mem_req.addr, `OFF_ADC_CONFIG_HI)) begin
            rdata_nxt = acfg_hi_r;
         end else begin
            rdata_nxt = `RST_BYTE;  // unmapped or write-only reads as zero
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_r  <= `RST_BYTE;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // ==========================================================
   // external amplifier controls; unselected pair is held low
   always_comb begin
      pa_level  = opt_r[`BIT_EXT_AMP_OUT_EN] && (radio_state == transmit_state);
      lna_level = opt_r[`BIT_EXT_RX_AMP_EN] && (radio_state == receive_state);
      pins_nxt.pa_1v8  = pa_level && !pinsel_r[`BIT_EXT_AMP_PIN_SEL];
      pins_nxt.lna_1v8 = lna_level && !pinsel_r[`BIT_EXT_AMP_PIN_SEL];
      pins_nxt.pa_vdd  = pa_level && pinsel_r[`BIT_EXT_AMP_PIN_SEL];
      pins_nxt.lna_vdd = lna_level && pinsel_r[`BIT_EXT_AMP_PIN_SEL];
   end

   // registered so the pads never see a decode glitch
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pins_r <= '0;
      end else begin
         pins_r <= pins_nxt;
      end
   end

   assign amp_pins         = pins_r;
   assign wakeup_ctrl      = wctl_r;
   assign mem_rdata        = rdata_r;
   assign mem_rvalid       = rvalid_r;
   assign adc_source_sel   = acfg_lo_r;
   assign adc_ref_power_on = acfg_hi_r[`BIT_ADC_REF_POWER];
   assign agc_filter_on    = (filt_mode == filt_all);

endmodule

`default_nettype wire

// ---- rtl/radio_aux_defines.svh ----
/*
 Offsets, field positions, reset values and counts of the auxiliary radio
 control registers. Assumes a 10-bit memory address and 8-bit data.
*/
`ifndef RADIO_AUX_DEFINES_SVH
`define RADIO_AUX_DEFINES_SVH

// ==========================================================
// register offsets
`define OFF_OPERATING_OPTION   10'h11A
`define OFF_EXT_AMP_PIN_SEL    10'h11B
`define OFF_WAKEUP_CFG_HI      10'h30C
`define OFF_WAKEUP_CFG_LO      10'h30D
`define OFF_WAKEUP_VAL_HI      10'h30E
`define OFF_WAKEUP_VAL_LO      10'h30F
`define OFF_WAKEUP_FLAG_CLEAR  10'h310
`define OFF_WAKEUP_STATE       10'h311
`define OFF_ADC_READBACK_HI    10'h327
`define OFF_ADC_READBACK_LO    10'h328
`define OFF_ADC_CONFIG_LO      10'h359
`define OFF_ADC_CONFIG_HI      10'h35A

// modem configuration memory window (bits 9:8 of the address)
`define MODEM_CFG_PAGE         2'h3

// ==========================================================
// field positions
`define BIT_EXT_AMP_OUT_EN     3
`define BIT_EXT_RX_AMP_EN      2
`define BIT_EXT_AMP_PIN_SEL    0
`define BIT_ADC_REF_POWER      4
`define FLD_ADC_FILT_HI        6
`define FLD_ADC_FILT_LO        5

// ==========================================================
// reset values
`define RST_OPERATING_OPTION   8'h00
`define RST_EXT_AMP_PIN_SEL    8'h00
`define RST_WAKEUP_CFG         8'h00
`define RST_WAKEUP_VAL         8'h00
`define RST_ADC_CONFIG_LO      8'h00
`define RST_ADC_CONFIG_HI      8'h1F
`define RST_BYTE               8'h00

// ==========================================================
// timing counts
`define AGC_TICK_DIV           8'd16

`endif

// ---- rtl/radio_aux_pkg.sv ----
/*
 Types shared by the auxiliary radio control registers and the ADC
 readback path. Assumes radio_aux_defines.svh is not needed here.
*/
package radio_aux_pkg;

   // radio state as reported by the radio controller
   typedef enum logic [2:0] {
      off_state,
      on_state,
      receive_state,
      transmit_state,
      sleep_state
   } radio_state_type;

   // ADC filtering modes
   typedef enum logic [1:0] {
      filt_none,
      filt_rb_on_read,
      filt_rb_on_tick,
      filt_all
   } adc_filter_type;

   // one memory access from the SPI command decoder
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [9:0] addr;
      logic [7:0] wdata;
   } mem_req_type;

   // external amplifier control pins, two pin pairs
   typedef struct packed {
      logic pa_1v8;
      logic lna_1v8;
      logic pa_vdd;
      logic lna_vdd;
   } amp_pins_type;

   // wake-up timer settings handed to the timer
   typedef struct packed {
      logic [15:0] config_word;
      logic [15:0] value_word;
      logic        value_load;
      logic        flag_clear;
   } wakeup_ctrl_type;

endpackage

// ---- tb/host_spi_model.sv ----
/* host side of the memory access path: register write, read and readback.
 assumes one access per request and the read answer one cycle later. */
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
   input  wire logic                      ref_clk,
   output var radio_aux_pkg::mem_req_type mem_req,
   input  wire logic [7:0]                mem_rdata,
   input  wire logic                      mem_rvalid
);
   import radio_aux_pkg::*;
   initial mem_req = '0;
   // released address and data show the inverse, never a stale copy
   task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      mem_req <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk);
      mem_req <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   // a missing answer reads as unknown so the compare fails
   task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      mem_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge ref_clk);
      mem_req <= '{1'b0, 1'b0, ~a, 8'hFF};
      @(posedge ref_clk);
      d = (mem_rvalid === 1'b1) ? mem_rdata : 8'hXX;
   endtask
   // high byte always goes first so the low byte never lands alone
   task automatic pair_write(input logic [9:0] hi_addr, input logic [15:0] v);
      wr_reg(hi_addr, v[15:8]);
      wr_reg(hi_addr + 10'h001, v[7:0]);
   endtask
   task automatic adc_cfg_write(input logic [7:0] d);
      wr_reg(10'h35A, d | 8'h0F);
   endtask
   task automatic readback(output logic [7:0] lo, output logic [7:0] hi);
      logic [7:0] first;
      rd_reg(10'h327, first);
      rd_reg(10'h328, lo);
      rd_reg(10'h327, hi);
   endtask
endmodule
`default_nettype wire

// ---- tb/radio_aux_control_registers_tb.sv ----
/* self-checking bench of the auxiliary radio registers.
 assumes the host model and the bound checker are present. */
`timescale 1ns/1ps
`default_nettype none
`include "radio_aux_defines.svh"
module radio_aux_control_registers_tb;
   import radio_aux_pkg::*;
   logic            ref_clk = 1'b0;
   logic            nrst = 1'b0;
   mem_req_type     mem_req;
   logic [7:0]      mem_rdata, wakeup_status, adc_sample, agc_sample, adc_source_sel, d, lo, hi;
   logic            mem_rvalid, adc_ref_power_on, agc_filter_on;
   radio_state_type radio_state;
   amp_pins_type    amp_pins;
   wakeup_ctrl_type wakeup_ctrl;
   logic [15:0]     v;
   int              n_errors = 0;
   int              check_count = 0;
   always #5 ref_clk = ~ref_clk;
   radio_aux_control_registers radio_aux_control_registers_inst (.ref_clk(ref_clk),
      .nrst(nrst), .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
      .radio_state(radio_state), .amp_pins(amp_pins), .wakeup_ctrl(wakeup_ctrl),
      .wakeup_status(wakeup_status), .adc_sample(adc_sample), .adc_source_sel(adc_source_sel),
      .adc_ref_power_on(adc_ref_power_on), .agc_filter_on(agc_filter_on),
      .agc_sample(agc_sample));
   host_spi_model host_spi_model_inst (.ref_clk(ref_clk), .mem_req(mem_req),
      .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
   // ==========================================================
   // checking helpers
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic amp_pins_type exp_pins(input logic [7:0] opt, input logic sel,
                                             input radio_state_type st);
      logic pa, lna;
      pa = opt[`BIT_EXT_AMP_OUT_EN] && st == transmit_state;
      lna = opt[`BIT_EXT_RX_AMP_EN] && st == receive_state;
      return sel ? {2'b00, pa, lna} : {pa, lna, 2'b00};
   endfunction
   task automatic wrap_up;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // watchdog: over a hundred times the expected run
   initial begin
      #200000;
      n_errors++;
      wrap_up();
   end
   // ==========================================================
   // main sequence
   initial begin
      radio_state = off_state;
      wakeup_status = 8'h00;
      adc_sample = 8'h00;
      void'($urandom(32'h41c2));
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      host_spi_model_inst.rd_reg(`OFF_ADC_CONFIG_HI, d);
      chk("cfg_hi reset", {8'h00, `RST_ADC_CONFIG_HI}, {8'h00, d});
      host_spi_model_inst.rd_reg(10'h000, d);
      chk("unmapped", 16'h0000, {8'h00, d});
      // every radio state with both pin pairs, both enables set on the 1.8 V pair and random ones on the supply-level pair
      for (int i = 0; i < 10; i++) begin
         v = (i < 5) ? 16'h000C : 16'($urandom);
         host_spi_model_inst.wr_reg(`OFF_OPERATING_OPTION, v[7:0]);
         host_spi_model_inst.wr_reg(`OFF_EXT_AMP_PIN_SEL, {7'h00, i >= 5});
         @(posedge ref_clk);
         radio_state <= radio_state_type'(i % 5);
         repeat (3) @(posedge ref_clk);
         chk("amp pins", {12'h000, exp_pins(v[7:0], i >= 5, radio_state_type'(i % 5))},
             {12'h000, amp_pins});
      end
      radio_state <= on_state;
      // timer value: lone high byte waits for the low byte
      v = 16'($urandom);
      host_spi_model_inst.pair_write(`OFF_WAKEUP_VAL_HI, v);
      @(posedge ref_clk);
      chk("value word", v, wakeup_ctrl.value_word);
      host_spi_model_inst.wr_reg(`OFF_WAKEUP_VAL_HI, ~v[15:8]);
      @(posedge ref_clk);
      chk("value held", v, wakeup_ctrl.value_word);
      host_spi_model_inst.pair_write(`OFF_WAKEUP_CFG_HI, ~v);
      @(posedge ref_clk);
      chk("config word", ~v, wakeup_ctrl.config_word);
      host_spi_model_inst.wr_reg(`OFF_ADC_CONFIG_LO, v[15:8]);
      host_spi_model_inst.wr_reg(`OFF_WAKEUP_FLAG_CLEAR, v[7:0]);
      @(posedge ref_clk);
      chk("flag clear", 16'h0001, {15'h0, wakeup_ctrl.flag_clear});
      chk("source sel", {8'h00, v[15:8]}, {8'h00, adc_source_sel});
      // modem page is wiped in sleep
      host_spi_model_inst.adc_cfg_write(v[7:0] & 8'hE0);
      host_spi_model_inst.rd_reg(`OFF_ADC_CONFIG_HI, d);
      chk("cfg_hi", {8'h00, v[7:5], 5'h0F}, {8'h00, d});
      radio_state <= sleep_state;
      repeat (2) @(posedge ref_clk);
      host_spi_model_inst.rd_reg(`OFF_ADC_CONFIG_HI, d);
      chk("cfg_hi sleep", {8'h00, `RST_ADC_CONFIG_HI}, {8'h00, d});
      host_spi_model_inst.rd_reg(`OFF_WAKEUP_CFG_HI, d);
      chk("timer cfg sleep", {8'h00, `RST_WAKEUP_CFG}, {8'h00, d});
      radio_state <= on_state;
      // every filter code with both reference settings
      for (int i = 0; i < 8; i++) begin
         host_spi_model_inst.adc_cfg_write({1'b0, 2'(i), i >= 4, 4'h0});
         adc_sample <= 8'($urandom);
         repeat (3) @(posedge ref_clk);
         chk("ref power", {15'h0, i >= 4}, {15'h0, adc_ref_power_on});
         chk("gain filter", {15'h0, i % 4 == 3}, {15'h0, agc_filter_on});
         if (i % 4 != 3) chk("gain sample", {8'h00, adc_sample}, {8'h00, agc_sample});
      end
      // three-read readback of a raw sample, then the timer status
      host_spi_model_inst.adc_cfg_write(8'h10);
      host_spi_model_inst.readback(lo, hi);
      chk("readback lo", {14'h0, adc_sample[1:0]}, {8'h00, lo});
      chk("readback hi", {10'h0, adc_sample[7:2]}, {8'h00, hi});
      wakeup_status <= 8'($urandom);
      host_spi_model_inst.rd_reg(`OFF_WAKEUP_STATE, d);
      chk("timer status", {8'h00, wakeup_status}, {8'h00, d});
      wrap_up();
   end
endmodule
`default_nettype wire

// ---- tb/radio_aux_monitor.sv ----
/* checker of the auxiliary radio registers, bound to the top module.
 assumes single-cycle host accesses and one clock. */
`timescale 1ns/1ps
`default_nettype none
`include "radio_aux_defines.svh"
module radio_aux_monitor (
   input wire logic                          ref_clk,
   input wire logic                          nrst,
   input wire radio_aux_pkg::mem_req_type     mem_req,
   input wire logic [7:0]                    mem_rdata,
   input wire logic                          mem_rvalid,
   input wire radio_aux_pkg::radio_state_type radio_state,
   input wire radio_aux_pkg::amp_pins_type    amp_pins,
   input wire radio_aux_pkg::wakeup_ctrl_type wakeup_ctrl,
   input wire logic                          adc_ref_power_on,
   input wire logic                          agc_filter_on
);
   import radio_aux_pkg::*;
   logic [7:0] opt_r, opt_nxt, valhi_r, valhi_nxt, cfghi_r, cfghi_nxt;
   logic       sel_r, sel_nxt, sleep, wr;
   assign sleep = (radio_state == sleep_state);
   assign wr = mem_req.wr;
   // ==========================================================
   // mirror of the registers the checks depend on; sleep wipes modem page
   always_comb begin
      opt_nxt = opt_r;
      sel_nxt = sel_r;
      valhi_nxt = sleep ? `RST_WAKEUP_VAL : valhi_r;
      cfghi_nxt = sleep ? `RST_ADC_CONFIG_HI : cfghi_r;
      if (wr && mem_req.addr == `OFF_OPERATING_OPTION) opt_nxt = mem_req.wdata;
      if (wr && mem_req.addr == `OFF_EXT_AMP_PIN_SEL) sel_nxt = mem_req.wdata[0];
      if (wr && !sleep && mem_req.addr == `OFF_WAKEUP_VAL_HI) valhi_nxt = mem_req.wdata;
      if (wr && !sleep && mem_req.addr == `OFF_ADC_CONFIG_HI) cfghi_nxt = mem_req.wdata;
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         opt_r <= `RST_OPERATING_OPTION;
         sel_r <= 1'b0;
         valhi_r <= `RST_WAKEUP_VAL;
         cfghi_r <= `RST_ADC_CONFIG_HI;
      end else begin
         opt_r <= opt_nxt;
         sel_r <= sel_nxt;
         valhi_r <= valhi_nxt;
         cfghi_r <= cfghi_nxt;
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_pa_pins;
      {amp_pins.pa_1v8, amp_pins.pa_vdd} == $past({2{opt_r[3] && radio_state == transmit_state}}
         & {!sel_r, sel_r});
   endproperty
   a_pa_pins: assert property (p_pa_pins) else $error("pa control wrong");
   property p_lna_pins;
      {amp_pins.lna_1v8, amp_pins.lna_vdd} == $past({2{opt_r[2] && radio_state == receive_state}}
         & {!sel_r, sel_r});
   endproperty
   a_lna_pins: assert property (p_lna_pins) else $error("lna control wrong");
   property p_val_load;
      wr && !sleep && mem_req.addr == `OFF_WAKEUP_VAL_LO |=> wakeup_ctrl.value_load &&
         wakeup_ctrl.value_word == {valhi_r, $past(mem_req.wdata)};
   endproperty
   a_val_load: assert property (p_val_load) else $error("timer value not loaded");
   property p_val_hold;
      wr && !sleep && mem_req.addr == `OFF_WAKEUP_VAL_HI |=>
         !wakeup_ctrl.value_load && $stable(wakeup_ctrl.value_word);
   endproperty
   a_val_hold: assert property (p_val_hold) else $error("high byte applied early");
   property p_load_cause;
      wakeup_ctrl.value_load |-> $past(wr && mem_req.addr == `OFF_WAKEUP_VAL_LO);
   endproperty
   a_load_cause: assert property (p_load_cause) else $error("stray value load");
   property p_ref_power;
      $stable(cfghi_r) |-> adc_ref_power_on == cfghi_r[4];
   endproperty
   a_ref_power: assert property (p_ref_power) else $error("reference power wrong");
   property p_filter_on;
      $stable(cfghi_r) |-> agc_filter_on == (cfghi_r[6:5] == 2'b11);
   endproperty
   a_filter_on: assert property (p_filter_on) else $error("gain filter wrong");
   property p_sleep_read;
      sleep ##1 (sleep && mem_req.rd && mem_req.addr == `OFF_ADC_CONFIG_HI) |=>
         mem_rdata == `RST_ADC_CONFIG_HI;
   endproperty
   a_sleep_read: assert property (p_sleep_read) else $error("config kept in sleep");
   property p_lo_read;
      mem_req.rd && mem_req.addr == `OFF_ADC_READBACK_LO |=> mem_rvalid && mem_rdata[7:2] == 6'h00;
   endproperty
   a_lo_read: assert property (p_lo_read) else $error("low readback too wide");
endmodule
bind radio_aux_control_registers radio_aux_monitor radio_aux_monitor_inst (
   .ref_clk(ref_clk), .nrst(nrst), .mem_req(mem_req), .mem_rdata(mem_rdata),
   .mem_rvalid(mem_rvalid), .radio_state(radio_state), .amp_pins(amp_pins),
   .wakeup_ctrl(wakeup_ctrl), .adc_ref_power_on(adc_ref_power_on),
   .agc_filter_on(agc_filter_on));
`default_nettype wire
